// *** rtl/ecp_port_host.sv ***
// Purpose: ecp parallel port, host end, with fifo, dma and pio service
// Assumes: all inputs synchronous to clock; control bits are plain ports
// Notes:   pins lag internal state by one register stage
// Notes on behaviour
// - byte on data lines, strobe low, busy interlock
// - reverse byte valid while nack low; paired
// - reverse byte is command when periphack low
// - hostack high for data, low for command
// - reverse request low means reverse direction
// - selectin held deasserted in ecp mode
// - forward nfault falling edge raises error pulse
// - autofd asserted to request each reverse byte
// - command port bytes flagged, data port plain
// - auto handshake only in modes 010 and 011
// - mode and direction change restrictions
// - count byte precedes its data byte
// - fifo off after reset, used in fifo modes
// - dma serves data, test, compat ports only
// - terminal count sets pending, stops dma
// - pio service raised on interrupt line
// - external floppy forces drive b outputs inactive
// - floppy inputs ored with data lines 4..0
// - three bit mode field, 101 reserved
// - one sixteen byte buffer for all ports
`timescale 1ns/1ps
module ecp_port_host
  import ecp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // mode and control bits
  input  wire logic        mode_wr,
  input  wire logic [2:0]  mode_in,
  input  wire logic        dir_wr,
  input  wire logic        dir_in,
  input  wire logic        strobe_bit,
  input  wire logic        autofd_bit,
  input  wire logic        init_bit,
  input  wire logic        selectin_bit,
  input  wire logic [7:0]  pio_data,
  input  wire logic        fault_irq_enable,
  input  wire logic        dma_allow,
  input  wire logic        service_clear,
  // fifo ports
  input  wire logic        command_fifo_port_wr,
  input  wire logic        data_fifo_port_wr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        data_fifo_port_rd,
  input  wire logic        dma_tc,
  // status to software
  output logic [2:0]       mode,
  output logic             dir,
  output logic [7:0]       rd_data,
  output logic             rd_is_cmd,
  output logic             fifo_full,
  output logic             fifo_empty,
  output logic             service_pending,
  output logic             port_dma_request,
  output logic             irq,
  output logic             fault_event,
  // printer pins
  output logic [7:0]       pd_out,
  output logic             pd_oe,
  input  wire logic [7:0]  pd_in,
  output logic             nstrobe,
  output logic             nautofd,
  output logic             ninit,
  output logic             nselectin,
  input  wire logic        nack,
  input  wire logic        busy,
  input  wire logic        nackreverse,
  input  wire logic        nfault,
  // external floppy takeover
  input  wire logic        external_floppy_mode,
  input  wire logic        drive_b_motor_in,
  input  wire logic        drive_b_select_in,
  input  wire logic [4:0]  fdc_pins_in,
  output logic             drive_b_motor_out,
  output logic             drive_b_select_out,
  output logic [4:0]       fdc_sense
);
  logic             rst_meta;
  logic             rst_n;
  ecp_state_e       state;
  logic [7:0]       out_byte;
  logic             hostack;
  logic             nfault_d;
  logic             dir_eff;
  logic             fifo_used;
  logic             auto_fwd;
  logic             auto_rev;
  logic             fwd_go;
  logic             rev_push;
  logic             sw_push;
  logic             sw_pop;
  logic             push;
  logic             pop;
  logic [FIFO_W-1:0] push_data;
  logic [FIFO_W-1:0] head;
  logic             f_full;
  logic             f_empty;
  logic [4:0]       f_count;
  logic             set_tc;
  logic             set_pio;

  function automatic logic is_pio_mode(input logic [2:0] m);
    return (m == MODE_STD) || (m == MODE_BIDIR);
  endfunction : is_pio_mode

  // reset release through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // mode field; a non-pio mode may only fall back to 000 or 001
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= RESET_MODE;
    end else if (mode_wr && mode_in != MODE_RSVD) begin
      if (is_pio_mode(mode) || is_pio_mode(mode_in)) mode <= mode_in;
    end
  end

  // direction only moves in mode 001
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir <= 1'b0;
    end else if (dir_wr && mode == MODE_BIDIR) begin
      dir <= dir_in;
    end
  end

  // modes 000 and 010 always drive forward
  assign dir_eff   = dir && mode != MODE_STD && mode != MODE_FIFO;
  assign fifo_used = mode == MODE_FIFO || mode == MODE_ECP ||
                     mode == MODE_TEST;
  assign auto_fwd  = (mode == MODE_FIFO || mode == MODE_ECP) && !dir_eff;
  assign auto_rev  = mode == MODE_ECP && dir_eff;

  // handshake decisions taken from the current state
  assign fwd_go   = state == ECP_IDLE && auto_fwd && !f_empty && !busy;
  assign rev_push = state == ECP_REQ && auto_rev && !nack && !f_full;

  // software and dma writes; command port only in ecp forward
  assign sw_push = (command_fifo_port_wr && mode == MODE_ECP && !dir_eff)
                || (data_fifo_port_wr && fifo_used && !auto_rev);
  assign sw_pop  = data_fifo_port_rd && !f_empty &&
                   (auto_rev || mode == MODE_TEST);
  assign push    = rev_push || sw_push;
  assign pop     = fwd_go || sw_pop;
  // command flag rides beside each byte so order survives the fifo
  assign push_data = rev_push ? {!busy, pd_in}
                   : {command_fifo_port_wr, wr_data};

  // single shared buffer, emptied whenever the fifo is unused
  ecp_fifo u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .clear     (!fifo_used),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .head      (head),
    .full      (f_full),
    .empty     (f_empty),
    .count     (f_count)
  );

  // forward and reverse handshake engine
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ECP_IDLE;
      out_byte <= 8'h00;
      hostack  <= 1'b1;
    end else if (!auto_fwd && !auto_rev) begin
      state <= ECP_IDLE;
    end else begin
      unique case (state)
        ECP_IDLE: begin
          if (fwd_go) begin
            out_byte <= head[7:0];
            hostack  <= !(mode == MODE_ECP && head[CMD_BIT]);
            state    <= ECP_SETUP;
          end else if (auto_rev && !nackreverse && !f_full) begin
            state <= ECP_REQ;
          end
        end
        ECP_SETUP:   state <= ECP_STROBE;
        ECP_STROBE:  if (busy) state <= ECP_RELEASE;
        ECP_RELEASE: if (!busy) state <= ECP_IDLE;
        ECP_REQ:     if (rev_push) state <= ECP_TAKE;
        ECP_TAKE:    if (nack) state <= ECP_IDLE;
        default:     state <= ECP_IDLE;
      endcase
    end
  end

  // pin drivers; pio modes pass strobe, autofd and selectin inverted, init as is
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_out    <= 8'h00;
      pd_oe     <= 1'b0;
      nstrobe   <= 1'b1;
      nautofd   <= 1'b1;
      ninit     <= 1'b1;
      nselectin <= 1'b1;
    end else begin
      pd_out  <= auto_fwd ? out_byte : pio_data;
      // in mode 011, waits for the peripheral to give the bus back first
      pd_oe   <= !dir_eff && !external_floppy_mode &&
                 (mode != MODE_ECP || nackreverse);
      nstrobe <= auto_fwd ? (state != ECP_STROBE) : !strobe_bit;
      if (auto_fwd && mode == MODE_ECP) nautofd <= hostack;
      else if (auto_rev) nautofd <= (state != ECP_REQ);
      else nautofd <= !autofd_bit;
      ninit     <= (mode == MODE_ECP) ? !dir_eff : init_bit;
      nselectin <= (mode == MODE_ECP) ? 1'b1 : !selectin_bit;
    end
  end

  // software read port and status copies
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data    <= 8'h00;
      rd_is_cmd  <= 1'b0;
      fifo_full  <= 1'b0;
      fifo_empty <= 1'b1;
    end else begin
      if (sw_pop) begin
        rd_data   <= head[7:0];
        rd_is_cmd <= head[CMD_BIT];
      end
      fifo_full  <= f_full;
      fifo_empty <= f_empty;
    end
  end

  // service events: terminal count, or pio threshold reached
  assign set_tc  = dma_tc && dma_allow && !service_pending;
  assign set_pio = !dma_allow && !service_pending && fifo_used &&
                   (dir_eff ? f_count >= READ_THRESH
                            : (DEPTH_COUNT - f_count) >= WRITE_THRESH);

  // pending flag: a set in the clearing cycle is kept
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      service_pending <= 1'b0;
      irq             <= 1'b0;
    end else begin
      if (set_tc || set_pio) service_pending <= 1'b1;
      else if (service_clear) service_pending <= 1'b0;
      irq <= set_tc || set_pio;
    end
  end

  // dma request; forward needs room, reverse needs data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_dma_request <= 1'b0;
    end else begin
      port_dma_request <= dma_allow && !service_pending && !set_tc &&
                          fifo_used &&
                          (dir_eff ? !f_empty : !f_full);
    end
  end

  // error pulse on a falling nfault, forward ecp only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nfault_d    <= 1'b1;
      fault_event <= 1'b0;
    end else begin
      nfault_d    <= nfault;
      fault_event <= nfault_d && !nfault && mode == MODE_ECP &&
                     !dir_eff && fault_irq_enable;
    end
  end

  // floppy takeover; drive b outputs are active low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drive_b_motor_out  <= 1'b1;
      drive_b_select_out <= 1'b1;
      fdc_sense          <= 5'h00;
    end else begin
      drive_b_motor_out  <= external_floppy_mode || drive_b_motor_in;
      drive_b_select_out <= external_floppy_mode || drive_b_select_in;
      fdc_sense <= fdc_pins_in |
                   (external_floppy_mode ? pd_in[4:0] : 5'h00);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_strobed;
    $fell(nstrobe) ##[1:1000] busy;
  endsequence
  sequence s_fwd_start;
    fwd_go && mode == MODE_ECP;
  endsequence

  a_strobe_release: assert property (s_strobed |-> ##[1:3] nstrobe)
    else $error("strobe not released after busy");
  a_strobe_data: assert property (!nstrobe |-> $stable(pd_out))
    else $error("data changed under strobe");
  a_hostack_level: assert property (s_fwd_start |->
    ##2 (nautofd == !$past(head[CMD_BIT], 2)))
    else $error("hostack does not match command flag");
  a_rev_request: assert property (rev_push |-> !nautofd)
    else $error("reverse byte taken without request");
  a_no_drive: assert property ((mode == MODE_ECP && !nackreverse)[*2]
    |-> !pd_oe)
    else $error("data driven before ackreverse");
  a_reverse_init: assert property ((mode == MODE_ECP && dir_eff)[*2]
    |-> !ninit)
    else $error("reverse request not asserted");
  a_selectin_off: assert property ((mode == MODE_ECP)[*2] |-> nselectin)
    else $error("selectin asserted in ecp mode");
  a_mode_lock: assert property ((mode_wr && !is_pio_mode(mode) &&
    !is_pio_mode(mode_in)) |=> mode == $past(mode))
    else $error("illegal mode switch taken");
  a_tc_stop: assert property ((dma_tc && dma_allow) |=>
    service_pending ##1 !port_dma_request)
    else $error("dma kept running after terminal count");
  a_fifo_off: assert property ((mode == MODE_STD)[*3] |-> fifo_empty)
    else $error("fifo holds data in mode 000");
  a_floppy_off: assert property (external_floppy_mode |=>
    drive_b_motor_out && drive_b_select_out)
    else $error("drive b active in floppy takeover");
endmodule : ecp_port_host

// *** rtl/ecp_pkg.sv ***
// Purpose: shared constants for the ecp host port
// Assumes: 250 MHz clock, byte wide port, one shared fifo
// Notes:   fifo word is {command flag, byte}
package ecp_pkg;
  // port modes
  localparam logic [2:0] MODE_STD   = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_FIFO  = 3'h2;
  localparam logic [2:0] MODE_ECP   = 3'h3;
  localparam logic [2:0] MODE_EPP   = 3'h4;
  localparam logic [2:0] MODE_RSVD  = 3'h5;
  localparam logic [2:0] MODE_TEST  = 3'h6;
  localparam logic [2:0] MODE_CFG   = 3'h7;
  localparam logic [2:0] RESET_MODE = MODE_STD;
  // fifo shape
  localparam int BYTE_W     = 8;
  localparam int FIFO_W     = 9;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam int CMD_BIT    = 8;
  // service thresholds for programmed i/o
  localparam logic [4:0] WRITE_THRESH = 5'h08;
  localparam logic [4:0] READ_THRESH  = 5'h08;
  localparam logic [4:0] DEPTH_COUNT  = 5'h10;
  // handshake states, gray along the usual path
  typedef enum logic [2:0] {
    ECP_IDLE    = 3'h0,
    ECP_SETUP   = 3'h1,
    ECP_STROBE  = 3'h3,
    ECP_RELEASE = 3'h2,
    ECP_REQ     = 3'h6,
    ECP_TAKE    = 3'h7
  } ecp_state_e;
endpackage : ecp_pkg

// *** rtl/ecp_fifo.sv ***
// Purpose: sixteen word fifo shared by every fifo port
// Assumes: nothing of callers; push when full and pop when empty are ignored
// Notes:   head word shows combinationally
`timescale 1ns/1ps
module ecp_fifo
  import ecp_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clear,
  // fill side
  input  wire logic              push,
  input  wire logic [FIFO_W-1:0] push_data,
  // drain side
  input  wire logic              pop,
  output logic      [FIFO_W-1:0] head,
  // status
  output logic                   full,
  output logic                   empty,
  output logic      [4:0]        count
);
  logic [FIFO_W-1:0]  mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr;
  logic [FIFO_AW-1:0] rd_ptr;

  // storage, no reset needed on data
  always_ff @(posedge clock) begin
    if (push && !full) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // pointers and fill count; clear wins over traffic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push && !full) wr_ptr <= wr_ptr + FIFO_AW'(1);
      if (pop && !empty) rd_ptr <= rd_ptr + FIFO_AW'(1);
      count <= count + 5'((push && !full)) - 5'((pop && !empty));
    end
  end

  assign head  = mem[rd_ptr];
  assign full  = (count == DEPTH_COUNT);
  assign empty = (count == 5'h00);
endmodule : ecp_fifo

// *** tb/ecp_periph_model.sv ***
// Purpose: behavioural ecp peripheral facing the host port pins
// Assumes: host pins change only at rising clock edges
// Notes:   rx_q logs {hostack, byte}; tx_q holds {command, byte}
`timescale 1ns/1ps
module ecp_periph_model (
  // clock
  input  wire logic       clock,
  // host driven pins
  input  wire logic [7:0] pd_out,
  input  wire logic       pd_oe,
  input  wire logic       nstrobe,
  input  wire logic       nautofd,
  input  wire logic       ninit,
  // peripheral driven pins
  output logic      [7:0] pd_in,
  output logic            nack,
  output logic            busy,
  output logic            nackreverse
);
  logic [8:0] rx_q[$];
  logic [8:0] tx_q[$];
  int         slow = 0;
  logic       clash = 1'h0;
  logic       drv = 1'h0;
  logic [7:0] drv_byte = 8'h00;
  logic       tog = 1'h0;
  logic       disk_on = 1'h0;
  logic [4:0] disk_lines = 5'h1f;

  // released lines never keep the last byte, so stale data cannot pass;
  // in floppy takeover the drive's open-drain lines sit on pull-ups
  assign pd_in = pd_oe ? pd_out : drv ? drv_byte :
                 disk_on ? {3'h7, disk_lines} : (8'h5a ^ {8{tog}});

  // pattern toggle and drive clash watch
  always @(posedge clock) begin
    tog <= ~tog;
    if (pd_oe && drv) clash <= 1'h1;
  end

  // forward latch and reverse send, slow adds wait states
  initial begin
    nack = 1'h1;
    busy = 1'h0;
    nackreverse = 1'h1;
    forever begin
      @(posedge clock);
      if (!nstrobe && ninit && !busy) begin
        rx_q.push_back({nautofd, pd_in});
        repeat (slow) @(posedge clock);
        busy <= 1'h1;
        while (!nstrobe) @(posedge clock);
        repeat (slow) @(posedge clock);
        busy <= 1'h0;
      end else if (!ninit) begin
        nackreverse <= 1'h0;
        if (!nautofd && !nackreverse && tx_q.size() > 0) begin
          drv <= 1'h1;
          drv_byte <= tx_q[0][7:0];
          busy <= ~tx_q[0][8];
          tx_q.pop_front();
          @(posedge clock);
          nack <= 1'h0;
          while (!nautofd) @(posedge clock);
          nack <= 1'h1;
          drv <= 1'h0;
        end
      end else begin
        nackreverse <= 1'h1;
        busy <= 1'h0;
      end
    end
  end
endmodule : ecp_periph_model

// *** tb/test_ecp_parallel_port_host.sv ***
// Purpose: self-checking bench for the ecp host port
// Assumes: peripheral model on the far side, nfault driven here
// Notes:   inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module test_ecp_parallel_port_host;
  import ecp_pkg::*;
  logic       clock = 1'h0, resetn = 1'h0;
  logic       mode_wr = 1'h0, dir_wr = 1'h0, dir_in = 1'h0;
  logic [2:0] mode_in = 3'h0;
  logic       strobe_bit = 1'h0, autofd_bit = 1'h0;
  logic       init_bit = 1'h1, selectin_bit = 1'h0;
  logic [7:0] pio_data = 8'h05, wr_data = 8'h00;
  logic       fault_irq_enable = 1'h0, dma_allow = 1'h0;
  logic       service_clear = 1'h0, dma_tc = 1'h0, nfault = 1'h1;
  logic       command_fifo_port_wr = 1'h0, data_fifo_port_wr = 1'h0;
  logic       data_fifo_port_rd = 1'h0, external_floppy_mode = 1'h0;
  logic       drive_b_motor_in = 1'h0, drive_b_select_in = 1'h0;
  logic [4:0] fdc_pins_in = 5'h10;
  logic [2:0] mode;
  logic [7:0] rd_data, pd_out, pd_in;
  logic       dir, rd_is_cmd, fifo_full, fifo_empty, service_pending;
  logic       port_dma_request, irq, fault_event, pd_oe, hit;
  logic       nstrobe, nautofd, ninit, nselectin, nack, busy, nackreverse;
  logic       drive_b_motor_out, drive_b_select_out;
  logic [4:0] fdc_sense;
  int         bad_count = 0, num_checks = 0, cycles = 0, k;

  // device under test, all ports by name
  ecp_port_host i_dut (.clock, .resetn, .mode_wr, .mode_in, .dir_wr,
    .dir_in, .strobe_bit, .autofd_bit, .init_bit, .selectin_bit,
    .pio_data, .fault_irq_enable, .dma_allow, .service_clear,
    .command_fifo_port_wr, .data_fifo_port_wr, .wr_data,
    .data_fifo_port_rd, .dma_tc, .mode, .dir, .rd_data, .rd_is_cmd,
    .fifo_full, .fifo_empty, .service_pending, .port_dma_request, .irq,
    .fault_event, .pd_out, .pd_oe, .pd_in, .nstrobe, .nautofd, .ninit,
    .nselectin, .nack, .busy, .nackreverse, .nfault,
    .external_floppy_mode, .drive_b_motor_in, .drive_b_select_in,
    .fdc_pins_in, .drive_b_motor_out, .drive_b_select_out, .fdc_sense);

  // far side peripheral
  ecp_periph_model i_periph (.clock, .pd_out, .pd_oe, .nstrobe, .nautofd,
    .ninit, .pd_in, .nack, .busy, .nackreverse);

  // clock and hang guard
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run;
    end
  end

  task automatic chk(input string what, input logic [8:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic set_mode(input logic [2:0] m);
    @(posedge clock);
    mode_wr <= 1'h1;
    mode_in <= m;
    @(posedge clock);
    mode_wr <= 1'h0;
    repeat (2) @(negedge clock);
  endtask : set_mode

  task automatic set_dir(input logic d);
    @(posedge clock);
    dir_wr <= 1'h1;
    dir_in <= d;
    @(posedge clock);
    dir_wr <= 1'h0;
    repeat (2) @(negedge clock);
  endtask : set_dir

  // one-cycle pulses are sampled every cycle of the window
  task automatic await_pulse(input bit fault, input int n);
    hit = 1'h0;
    repeat (n) begin
      @(negedge clock);
      if ((fault ? fault_event : irq) === 1'h1) hit = 1'h1;
    end
  endtask : await_pulse

  task automatic test_reset;
    @(negedge clock);
    chk("mode and dir", 9'h000, {5'h00, mode, dir});
    chk("idle pins", 9'h07f, {2'h0, nstrobe, nautofd, ninit, nselectin,
        drive_b_motor_out, drive_b_select_out, fifo_empty});
    chk("service", 9'h000, {7'h00, service_pending, port_dma_request});
  endtask : test_reset

  task automatic test_modes;
    set_mode(MODE_RSVD);
    chk("reserved mode", 9'(MODE_STD), 9'(mode));
    set_dir(1'h1);
    chk("dir in 000", 9'h000, 9'(dir));
    @(posedge clock);
    data_fifo_port_wr <= 1'h1;
    @(posedge clock);
    data_fifo_port_wr <= 1'h0;
    repeat (4) @(negedge clock);
    chk("fifo in 000", 9'h001, 9'(fifo_empty));
    set_mode(MODE_ECP);
    chk("000 to 011", 9'(MODE_ECP), 9'(mode));
    chk("select in ecp", 9'h001, 9'(nselectin));
    set_mode(MODE_FIFO);
    chk("011 to 010", 9'(MODE_ECP), 9'(mode));
    set_mode(MODE_BIDIR);
    chk("011 to 001", 9'(MODE_BIDIR), 9'(mode));
    set_dir(1'h1);
    chk("dir in 001", 9'h001, 9'(dir));
    set_dir(1'h0);
    set_mode(MODE_STD);
  endtask : test_modes

  // count then data written back to back, slow peripheral
  task automatic test_forward;
    i_periph.slow = 3;
    set_mode(MODE_ECP);
    @(posedge clock);
    command_fifo_port_wr <= 1'h1;
    wr_data <= 8'h85;
    @(posedge clock);
    command_fifo_port_wr <= 1'h0;
    data_fifo_port_wr <= 1'h1;
    wr_data <= 8'h41;
    @(posedge clock);
    data_fifo_port_wr <= 1'h0;
    for (k = 0; k < 300 && i_periph.rx_q.size() < 2; k++) @(negedge clock);
    chk("bytes sent", 9'h002, 9'(i_periph.rx_q.size()));
    chk("count byte", 9'h085, i_periph.rx_q[0]);
    chk("data byte", 9'h141, i_periph.rx_q[1]);
    chk("select in ecp", 9'h001, 9'(nselectin));
    // leave only once the last strobe and busy cycle have closed
    for (k = 0; k < 50 && (!fifo_empty || busy || !nstrobe); k++)
      @(negedge clock);
    set_mode(MODE_STD);
    set_mode(MODE_FIFO);
    @(posedge clock);
    data_fifo_port_wr <= 1'h1;
    wr_data <= 8'h3c;
    @(posedge clock);
    data_fifo_port_wr <= 1'h0;
    for (k = 0; k < 300 && i_periph.rx_q.size() < 3; k++) @(negedge clock);
    chk("fifo mode byte", 9'h13c, i_periph.rx_q[2]);
    for (k = 0; k < 50 && (!fifo_empty || busy || !nstrobe); k++)
      @(negedge clock);
    set_mode(MODE_STD);
    i_periph.slow = 0;
  endtask : test_forward

  // test mode fills the shared buffer, drops one extra, reads in order
  task automatic test_fifo_full;
    set_mode(MODE_TEST);
    for (k = 0; k < 17; k++) begin
      @(posedge clock);
      data_fifo_port_wr <= 1'h1;
      wr_data <= 8'(k);
    end
    @(posedge clock);
    data_fifo_port_wr <= 1'h0;
    repeat (2) @(negedge clock);
    chk("fifo full", 9'h002, {7'h00, fifo_full, fifo_empty});
    for (k = 0; k < 16; k++) begin
      @(posedge clock);
      data_fifo_port_rd <= 1'h1;
      @(posedge clock);
      data_fifo_port_rd <= 1'h0;
      @(negedge clock);
      chk("test fifo byte", 9'(k), {rd_is_cmd, rd_data});
    end
    repeat (2) @(negedge clock);
    chk("fifo drained", 9'h001, {7'h00, fifo_full, fifo_empty});
    set_mode(MODE_STD);
  endtask : test_fifo_full

  // one data byte then one command byte from the peripheral
  task automatic test_reverse;
    i_periph.tx_q = '{9'h05a, 9'h112};
    set_mode(MODE_BIDIR);
    set_dir(1'h1);
    set_mode(MODE_ECP);
    for (k = 0; k < 300 && (i_periph.tx_q.size() > 0 || !nack); k++)
      @(negedge clock);
    repeat (4) @(negedge clock);
    chk("reverse request", 9'h000, 9'(ninit));
    chk("data released", 9'h000, 9'(pd_oe));
    for (int j = 0; j < 2; j++) begin
      @(posedge clock);
      data_fifo_port_rd <= 1'h1;
      @(posedge clock);
      data_fifo_port_rd <= 1'h0;
      @(negedge clock);
      chk("read byte", j ? 9'h012 : 9'h15a, {~rd_is_cmd, rd_data});
    end
    repeat (2) @(negedge clock);
    chk("drained", 9'h001, 9'(fifo_empty));
    chk("no clash", 9'h000, 9'(i_periph.clash));
    set_mode(MODE_BIDIR);
    set_dir(1'h0);
    set_mode(MODE_STD);
  endtask : test_reverse

  // pio service, dma request, terminal count and fault pulse
  task automatic test_service;
    @(posedge clock);
    dma_allow <= 1'h1;
    service_clear <= 1'h1;
    @(posedge clock);
    service_clear <= 1'h0;
    dma_allow <= 1'h0;
    mode_wr <= 1'h1;
    mode_in <= MODE_ECP;
    @(posedge clock);
    mode_wr <= 1'h0;
    await_pulse(1'h0, 8);
    chk("pio interrupt", 9'h001, 9'(hit));
    @(posedge clock);
    dma_allow <= 1'h1;
    service_clear <= 1'h1;
    @(posedge clock);
    service_clear <= 1'h0;
    repeat (3) @(negedge clock);
    chk("dma request", 9'h001, {7'h00, service_pending, port_dma_request});
    @(posedge clock);
    dma_tc <= 1'h1;
    @(posedge clock);
    dma_tc <= 1'h0;
    await_pulse(1'h0, 4);
    chk("tc interrupt", 9'h001, 9'(hit));
    chk("tc stops dma", 9'h002, {7'h00, service_pending, port_dma_request});
    @(posedge clock);
    fault_irq_enable <= 1'h1;
    nfault <= 1'h0;
    await_pulse(1'h1, 5);
    chk("fault pulse", 9'h001, 9'(hit));
    @(posedge clock);
    nfault <= 1'h1;
    dma_allow <= 1'h0;
    set_mode(MODE_STD);
  endtask : test_service

  task automatic test_floppy;
    chk("fdc sense normal", 9'h010, 9'(fdc_sense));
    chk("drive b normal", 9'h000, {7'h00, drive_b_motor_out,
        drive_b_select_out});
    i_periph.disk_lines = 5'h0a; // drive pulls some lines low
    i_periph.disk_on = 1'h1;
    @(posedge clock);
    external_floppy_mode <= 1'h1;
    repeat (3) @(negedge clock);
    chk("fdc sense ored", 9'h01a, 9'(fdc_sense));
    chk("drive b forced", 9'h003, {7'h00, drive_b_motor_out,
        drive_b_select_out});
  endtask : test_floppy

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // main sequence: reset held six cycles, then the scenarios
  initial begin
    repeat (5) @(posedge clock);
    test_reset;
    @(posedge clock);
    resetn <= 1'h1;
    repeat (3) @(posedge clock);
    test_modes;
    test_forward;
    test_reverse;
    test_service;
    test_fifo_full;
    test_floppy;
    complete_run;
  end
endmodule : test_ecp_parallel_port_host
